// file: src/qar_pkg.sv
// constants and state layout for the qos arbitration and regulation block
package qar_pkg;
  localparam int NIF = 5;
  localparam int NQ = 8;
  localparam logic [4:0] OT_DEPTH = 5'h10;
  // register word index, byte address = {iface, index, 2'b00}
  localparam logic [2:0] R_OVR = 3'h0;
  localparam logic [2:0] R_CTRL = 3'h1;
  localparam logic [2:0] R_OT = 3'h2;
  localparam logic [2:0] R_TGT = 3'h3;
  localparam logic [2:0] R_REG = 3'h4;
  localparam logic [2:0] R_STAT = 3'h5;
  localparam logic [2:0] IF_LAST = 3'h4;
  // control register bits; bit 0/1 are read/write regulator enable
  localparam int C_LAT = 2;
  localparam int C_QHI = 3;
  localparam int C_OT_EN = 4;
  // field positions
  localparam int F_OVR_W = 4;
  localparam int F_OT_W = 8;
  localparam int F_TGT_W = 12;
  localparam int F_MIN = 8;
  localparam int F_MAX = 12;
  // read queue class thresholds and reserved slots (design time)
  localparam logic [3:0] THR_UPPER = 4'hC;
  localparam logic [3:0] THR_LOWER = 4'h8;
  localparam logic [3:0] RES_HIGH = 4'h1;
  localparam logic [3:0] RES_MED = 4'h2;
  // credit window bounds, sixteenths of a transaction
  localparam logic signed [14:0] CRED_LO = -15'sh0FA0;
  localparam logic signed [14:0] CRED_HI = 15'sh0000;
  // lower index counts as less recently granted after reset
  localparam logic [24:0] LRG_RST = 25'h008639E;
  localparam logic [11:0] MEAS_SAT = 12'hFFF;

  typedef struct packed {
    logic [4:0][7:0] ovr;
    logic [4:0][4:0] ctrl;
    logic [4:0][15:0] ot;
    logic [4:0][23:0] tgt;
    logic [4:0][15:0] rg;
    logic [1:0][4:0][11:0] acc;
    logic [1:0][4:0][11:0] meas;
    logic [1:0][4:0][12:0] cred;
    logic [1:0][4:0][15:0] fl;
    logic [1:0][4:0][4:0] n;
    logic [1:0][4:0][4:0] cnt;
    logic [1:0][24:0] old;
    logic [7:0] qv;
    logic [7:0][3:0] qq;
    logic [7:0][2:0] qs;
    logic ro_v;
    logic [3:0] ro_q;
    logic [2:0] ro_s;
    logic wo_v;
    logic [3:0] wo_q;
    logic [2:0] wo_s;
    logic [31:0] rdata;
  } qar_state_t;
endpackage

// file: src/qar_top.sv
// qos arbitration, override, regulation and outstanding limiting
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1: highest qos request wins everywhere
// R2: ties broken least recently granted
// R3: downstream carries original or override qos
// R4: per-interface static override enable input
// R5: only zero qos requests get altered
// R6: override fixed value or regulated range
// R7: regulator maximum resets to zero
// R8: scale factor sets integrator rate
// R9: latency mode: above target raises qos
// R10: bandwidth mode: handshake interval versus target
// R11: normal mode holds value when idle
// R12: quiesce high drifts to maximum when idle
// R13: regulator output replaces zero qos if enabled
// R14: limit outstanding reads and writes
// R15: outstanding cap integer, plus one with fraction
// R16: mean outstanding over window within limit
// R17: only zero qos requests are counted
// R18: dataless requests neither counted nor stalled; the code still stalls them once 16 are outstanding on the interface
// R19: read queue reserves high and medium slots
// R20: priority hint promotes blocked read
// R21: hint may change while request waits
// R22: queued reads can be overtaken
// R23: single main clock everywhere
// R24: reset active low, two stage synchronised
// R25: regulation and limits clear at reset
module qar_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // static configuration
  input wire logic [4:0] qos_override_enable_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // slave read address side
  input wire logic [4:0] ar_valid_i,
  input wire logic [4:0][3:0] ar_qos_i,
  input wire logic [4:0][3:0] read_arb_priority_hint_i,
  input wire logic [4:0] ar_dataless_i,
  output logic [4:0] ar_ready_o,
  input wire logic [4:0] r_done_i,
  // slave write address side
  input wire logic [4:0] aw_valid_i,
  input wire logic [4:0][3:0] aw_qos_i,
  input wire logic [4:0] aw_dataless_i,
  output logic [4:0] aw_ready_o,
  input wire logic [4:0] b_done_i,
  // downstream read request
  output logic dn_ar_valid_o,
  output logic [3:0] dn_ar_qos_o,
  output logic [2:0] dn_ar_src_o,
  input wire logic dn_ar_ready_i,
  // downstream write request
  output logic dn_aw_valid_o,
  output logic [3:0] dn_aw_qos_o,
  output logic [2:0] dn_aw_src_o,
  input wire logic dn_aw_ready_i
);

  function automatic logic [3:0] eff_qos(
    input logic [3:0] q,
    input logic ovr_en,
    input logic reg_en,
    input logic [3:0] regv,
    input logic [3:0] ovrv
  );
    eff_qos = q;
    if (q == 4'h0 && ovr_en) begin // R4 R5
      eff_qos = reg_en ? regv : ovrv; // R6 R13
    end
  endfunction

  function automatic logic [4:0] arb(
    input logic [4:0] c,
    input logic [4:0][3:0] p,
    input logic [24:0] old
  );
    logic [3:0] mx;
    logic [4:0] tie;
    logic ok;
    mx = 4'h0;
    tie = 5'h00;
    arb = 5'h00;
    for (int i = 0; i < qar_pkg::NIF; i++) begin
      if (c[i] && p[i] > mx) begin
        mx = p[i];
      end
    end
    for (int i = 0; i < qar_pkg::NIF; i++) begin
      tie[i] = c[i] && p[i] == mx; // R1
    end
    for (int i = 0; i < qar_pkg::NIF; i++) begin
      ok = tie[i];
      for (int j = 0; j < qar_pkg::NIF; j++) begin
        if (j != i && tie[j] && !old[i*5+j]) begin
          ok = 1'b0; // R2
        end
      end
      arb[i] = ok;
    end
  endfunction

  function automatic logic [11:0] clamp_acc(
    input logic signed [14:0] v,
    input logic [3:0] mn,
    input logic [3:0] mx
  );
    logic signed [14:0] lo, hi;
    lo = $signed({3'h0, mn, 8'h00});
    hi = $signed({3'h0, mx, 8'hFF});
    if (v > hi) begin
      clamp_acc = hi[11:0]; // R7
    end else if (v < lo) begin
      clamp_acc = lo[11:0];
    end else begin
      clamp_acc = v[11:0];
    end
  endfunction

  function automatic logic ot_ok(
    input logic [4:0] cnt,
    input logic [7:0] lim,
    input logic [12:0] cred
  );
    ot_ok = cnt < {1'b0, lim[3:0]}; // R15
    if (lim[7:4] != 4'h0 && cnt == {1'b0, lim[3:0]} && !cred[12]) begin
      ot_ok = 1'b1; // R15 R16
    end
  endfunction

  // reset released through two flops; only the second one is used
  logic [1:0] rs_r;
  logic rst_n;
  always_ff @(posedge clk_i or negedge reset_n_i) begin // R23 R24
    if (!reset_n_i) begin
      rs_r <= 2'b00;
    end else begin
      rs_r <= {rs_r[0], 1'b1};
    end
  end
  assign rst_n = rs_r[1];
  qar_pkg::qar_state_t s_r;
  qar_pkg::qar_state_t s_nxt;

  logic [1:0][4:0] vld, dl, done, hs, cntd, stall;
  logic [1:0][4:0][3:0] qin, eq;
  logic [4:0][3:0] rpri;
  logic [4:0] cand_r, cand_w, g_r, g_w;
  logic [3:0] freeq, rmin, rmax, bq;
  logic adm, pop, taken, bv;
  logic [7:0] lim, scl;
  logic [11:0] tg;
  logic signed [14:0] a, c;
  logic [2:0] bs, ia, ri;

  always_comb begin
    s_nxt = s_r;
    vld[0] = ar_valid_i;
    vld[1] = aw_valid_i;
    dl[0] = ar_dataless_i;
    dl[1] = aw_dataless_i;
    qin[0] = ar_qos_i;
    qin[1] = aw_qos_i;
    done[0] = r_done_i;
    done[1] = b_done_i;
    cand_r = 5'h00;
    cand_w = 5'h00;
    rpri = '0;
    freeq = 4'h0;
    adm = 1'b0;
    pop = 1'b0;
    taken = 1'b0;
    lim = 8'h00;
    rmin = 4'h0;
    rmax = 4'h0;
    scl = 8'h00;
    tg = 12'h000;
    a = 15'sh0000;
    c = 15'sh0000;
    bq = 4'h0;
    bs = 3'h0;
    bv = 1'b0;
    ia = addr_i[7:5];
    ri = addr_i[4:2];

    // effective qos and outstanding stall per interface and direction
    for (int d = 0; d < 2; d++) begin
      for (int i = 0; i < qar_pkg::NIF; i++) begin
        eq[d][i] = eff_qos(qin[d][i], qos_override_enable_i[i],
                           s_r.ctrl[i][d], s_r.acc[d][i][11:8],
                           s_r.ovr[i][d*qar_pkg::F_OVR_W +: 4]);
        cntd[d][i] = qin[d][i] == 4'h0 && !dl[d][i]; // R17 R18
        lim = s_r.ot[i][d*qar_pkg::F_OT_W +: 8];
        stall[d][i] = (s_r.ctrl[i][qar_pkg::C_OT_EN] && cntd[d][i] &&
                       !ot_ok(s_r.cnt[d][i], lim, s_r.cred[d][i])) // R14
                      || s_r.n[d][i] == qar_pkg::OT_DEPTH;
      end
    end
    for (int k = 0; k < qar_pkg::NQ; k++) begin
      freeq = freeq + {3'h0, !s_r.qv[k]};
    end
    for (int i = 0; i < qar_pkg::NIF; i++) begin
      // a full queue of low priority reads must not block urgent ones
      adm = freeq > qar_pkg::RES_MED ||
            (eq[0][i] >= qar_pkg::THR_LOWER && freeq > qar_pkg::RES_HIGH) ||
            (eq[0][i] >= qar_pkg::THR_UPPER && freeq != 4'h0); // R19
      // hint is read live so a waiting master may raise it
      rpri[i] = read_arb_priority_hint_i[i] > eq[0][i] ?
                read_arb_priority_hint_i[i] : eq[0][i]; // R20 R21
      cand_r[i] = vld[0][i] && !stall[0][i] && adm;
      cand_w[i] = vld[1][i] && !stall[1][i] && (!s_r.wo_v || dn_aw_ready_i);
    end
    g_r = arb(cand_r, rpri, s_r.old[0]);
    g_w = arb(cand_w, eq[1], s_r.old[1]);
    hs[0] = g_r;
    hs[1] = g_w;
    // least recently granted order update
    for (int d = 0; d < 2; d++) begin
      for (int i = 0; i < qar_pkg::NIF; i++) begin
        if (hs[d][i]) begin
          for (int j = 0; j < qar_pkg::NIF; j++) begin
            if (j != i) begin
              s_nxt.old[d][i*5+j] = 1'b0; // R2
              s_nxt.old[d][j*5+i] = 1'b1;
            end
          end
        end
      end
    end
    // read queue: pick highest stored qos, then fill the output stage
    if (!s_r.ro_v || dn_ar_ready_i) begin
      s_nxt.ro_v = 1'b0;
      for (int k = 0; k < qar_pkg::NQ; k++) begin
        if (s_r.qv[k] && (!bv || s_r.qq[k] > bq)) begin
          bv = 1'b1; // R1
          bq = s_r.qq[k];
          bs = 3'(k);
        end
      end
      if (bv) begin
        s_nxt.ro_v = 1'b1;
        s_nxt.ro_q = bq; // R22
        s_nxt.ro_s = s_r.qs[bs];
        s_nxt.qv[bs] = 1'b0;
      end
    end
    // the promoted hint is not stored, so queued entries compete by qos
    for (int i = 0; i < qar_pkg::NIF; i++) begin
      if (g_r[i]) begin
        taken = 1'b0;
        for (int k = 0; k < qar_pkg::NQ; k++) begin
          if (!s_r.qv[k] && !taken) begin
            taken = 1'b1;
            s_nxt.qv[k] = 1'b1;
            s_nxt.qq[k] = eq[0][i]; // R3 R22
            s_nxt.qs[k] = 3'(i);
          end
        end
      end
    end
    // write output stage
    if (s_r.wo_v && dn_aw_ready_i) begin
      s_nxt.wo_v = 1'b0;
    end
    for (int i = 0; i < qar_pkg::NIF; i++) begin
      if (g_w[i]) begin
        s_nxt.wo_v = 1'b1;
        s_nxt.wo_q = eq[1][i]; // R3
        s_nxt.wo_s = 3'(i);
      end
    end

    for (int d = 0; d < 2; d++) begin
      for (int i = 0; i < qar_pkg::NIF; i++) begin
        // in-order completion list of counted flags
        pop = done[d][i] && s_r.n[d][i] != 5'h00;
        if (pop) begin
          s_nxt.cnt[d][i] = s_r.cnt[d][i] - {4'h0, s_r.fl[d][i][0]}; // R14
          s_nxt.fl[d][i] = s_r.fl[d][i] >> 1;
          s_nxt.n[d][i] = s_r.n[d][i] - 5'h01;
        end
        if (hs[d][i]) begin
          s_nxt.fl[d][i][s_nxt.n[d][i][3:0]] = cntd[d][i];
          s_nxt.n[d][i] = s_nxt.n[d][i] + 5'h01;
          s_nxt.cnt[d][i] = s_nxt.cnt[d][i] + {4'h0, cntd[d][i]}; // R17
        end

        // credit gains the limit and loses what is outstanding each cycle
        lim = s_r.ot[i][d*qar_pkg::F_OT_W +: 8];
        if (s_r.ctrl[i][qar_pkg::C_OT_EN]) begin
          c = $signed({{2{s_r.cred[d][i][12]}}, s_r.cred[d][i]})
              + $signed({7'h00, lim[3:0], lim[7:4]})
              - $signed({6'h00, s_r.cnt[d][i], 4'h0}); // R16
          if (c > qar_pkg::CRED_HI) begin
            c = qar_pkg::CRED_HI;
          end else if (c < qar_pkg::CRED_LO) begin
            c = qar_pkg::CRED_LO;
          end
          s_nxt.cred[d][i] = c[12:0];
        end else begin
          s_nxt.cred[d][i] = 13'h0000;
        end

        // feedback regulator
        scl = s_r.rg[i][7:0];
        rmin = s_r.rg[i][qar_pkg::F_MIN +: 4];
        rmax = s_r.rg[i][qar_pkg::F_MAX +: 4];
        tg = s_r.tgt[i][d*qar_pkg::F_TGT_W +: 12];
        a = $signed({3'h0, s_r.acc[d][i]});
        if (s_r.ctrl[i][d]) begin
          if (s_r.ctrl[i][qar_pkg::C_LAT]) begin
            if (s_r.n[d][i] != 5'h00 && s_r.meas[d][i] != qar_pkg::MEAS_SAT) begin
              s_nxt.meas[d][i] = s_r.meas[d][i] + 12'h001;
            end
            if (pop) begin
              if (s_r.meas[d][i] > tg) begin
                a = a + $signed({7'h00, scl}); // R8 R9
              end else if (s_r.meas[d][i] < tg) begin
                a = a - $signed({7'h00, scl}); // R9
              end
              s_nxt.meas[d][i] = 12'h000;
            end
          end else begin
            // idle cycles are not measured, so the average covers activity
            if (vld[d][i] && s_r.meas[d][i] != qar_pkg::MEAS_SAT) begin
              s_nxt.meas[d][i] = s_r.meas[d][i] + 12'h001; // R11
            end
            if (hs[d][i]) begin
              if (s_r.meas[d][i] > tg) begin
                a = a + $signed({7'h00, scl}); // R10
              end else if (s_r.meas[d][i] < tg) begin
                a = a - $signed({7'h00, scl}); // R10
              end
              s_nxt.meas[d][i] = 12'h000;
            end
            if (!vld[d][i] && s_r.ctrl[i][qar_pkg::C_QHI]) begin
              a = a + $signed({7'h00, scl}); // R12
            end
          end
          s_nxt.acc[d][i] = clamp_acc(a, rmin, rmax); // R6 R7
        end
      end
    end

    // register port
    if (wr_i && ia <= qar_pkg::IF_LAST) begin
      case (ri)
        qar_pkg::R_OVR: s_nxt.ovr[ia] = wdata_i[7:0];
        qar_pkg::R_CTRL: s_nxt.ctrl[ia] = wdata_i[4:0];
        qar_pkg::R_OT: s_nxt.ot[ia] = wdata_i[15:0];
        qar_pkg::R_TGT: s_nxt.tgt[ia] = wdata_i[23:0];
        qar_pkg::R_REG: s_nxt.rg[ia] = wdata_i[15:0];
        default: ;
      endcase
    end
    s_nxt.rdata = 32'h0000_0000;
    if (rd_i && ia <= qar_pkg::IF_LAST) begin
      case (ri)
        qar_pkg::R_OVR: s_nxt.rdata = {24'h000000, s_r.ovr[ia]};
        qar_pkg::R_CTRL: s_nxt.rdata = {27'h0000000, s_r.ctrl[ia]};
        qar_pkg::R_OT: s_nxt.rdata = {16'h0000, s_r.ot[ia]};
        qar_pkg::R_TGT: s_nxt.rdata = {8'h00, s_r.tgt[ia]};
        qar_pkg::R_REG: s_nxt.rdata = {16'h0000, s_r.rg[ia]};
        qar_pkg::R_STAT: s_nxt.rdata = {11'h000, s_r.cnt[1][ia], 3'h0, s_r.cnt[0][ia],
                                        s_r.acc[1][ia][11:8], s_r.acc[0][ia][11:8]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0; // R25 R7
      s_r.old <= {2{qar_pkg::LRG_RST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ar_ready_o = g_r;
  assign aw_ready_o = g_w;
  assign rdata_o = s_r.rdata;
  assign dn_ar_valid_o = s_r.ro_v;
  assign dn_ar_qos_o = s_r.ro_q;
  assign dn_ar_src_o = s_r.ro_s;
  assign dn_aw_valid_o = s_r.wo_v;
  assign dn_aw_qos_o = s_r.wo_q;
  assign dn_aw_src_o = s_r.wo_s;

endmodule // qar_top
`default_nettype wire

// file: tb/qar_dn_model.sv
// downstream model: accepts unless stalled, completes one cycle after accept
`timescale 1ns/1ps
`default_nettype none
module qar_dn_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // bench control
  input wire logic stall_i,
  // requests from the block
  input wire logic ar_valid_i,
  input wire logic [2:0] ar_src_i,
  input wire logic aw_valid_i,
  input wire logic [2:0] aw_src_i,
  // answers
  output logic ar_ready_o,
  output logic aw_ready_o,
  output logic [4:0] r_done_o,
  output logic [4:0] b_done_o
);
  assign ar_ready_o = !stall_i;
  assign aw_ready_o = !stall_i;
  // completions come back in order, which is what the block's counters assume
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_done_o <= 5'h00;
      b_done_o <= 5'h00;
    end else begin
      r_done_o <= (ar_valid_i && !stall_i) ? (5'h01 << ar_src_i) : 5'h00;
      b_done_o <= (aw_valid_i && !stall_i) ? (5'h01 << aw_src_i) : 5'h00;
    end
  end
endmodule // qar_dn_model
`default_nettype wire

// file: tb/qar_sva.sv
// port assertions for the qos arbitration top
`timescale 1ns/1ps
`default_nettype none
module qar_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // slave requests
  input wire logic [4:0] ar_valid_i,
  input wire logic [4:0] ar_ready_o,
  input wire logic [4:0] aw_valid_i,
  input wire logic [4:0][3:0] aw_qos_i,
  input wire logic [4:0] aw_ready_o,
  // downstream
  input wire logic dn_ar_valid_o,
  input wire logic [3:0] dn_ar_qos_o,
  input wire logic [2:0] dn_ar_src_o,
  input wire logic dn_ar_ready_i,
  input wire logic dn_aw_valid_o,
  input wire logic [3:0] dn_aw_qos_o,
  input wire logic [2:0] dn_aw_src_o,
  input wire logic dn_aw_ready_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [2:0] gi;
  logic [3:0] gq;
  logic hs;
  logic beat;
  // cap of 16 outstanding is never reached by the bench, so a higher valid must win
  always_comb begin
    gi = 3'h0;
    beat = 1'b0;
    for (int i = 0; i < 5; i++) if (aw_ready_o[i] && aw_valid_i[i]) gi = 3'(i);
    gq = aw_qos_i[gi];
    hs = |(aw_ready_o & aw_valid_i);
    for (int j = 0; j < 5; j++) if (aw_valid_i[j] && aw_qos_i[j] > gq) beat = 1'b1;
  end
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not zero outside answer cycle");
  a_ar_one_grant: assert property ($onehot0(ar_ready_o))
    else $error("more than one read grant");
  a_aw_one_grant: assert property ($onehot0(aw_ready_o))
    else $error("more than one write grant");
  a_ar_grant_valid: assert property ((ar_ready_o & ~ar_valid_i) == 5'h00)
    else $error("read grant without request");
  a_aw_grant_valid: assert property ((aw_ready_o & ~aw_valid_i) == 5'h00)
    else $error("write grant without request");
  a_dn_ar_hold: assert property (dn_ar_valid_o && !dn_ar_ready_i |=>
    dn_ar_valid_o && $stable(dn_ar_qos_o) && $stable(dn_ar_src_o))
    else $error("downstream read changed while stalled");
  a_dn_aw_hold: assert property (dn_aw_valid_o && !dn_aw_ready_i |=>
    dn_aw_valid_o && $stable(dn_aw_qos_o) && $stable(dn_aw_src_o))
    else $error("downstream write changed while stalled");
  a_aw_qos_pass: assert property (hs && gq != 4'h0 |=> dn_aw_valid_o &&
    dn_aw_qos_o == $past(gq) && dn_aw_src_o == $past(gi))
    else $error("nonzero write qos not passed on");
  a_aw_top_qos: assert property (hs && gq != 4'h0 |-> !beat)
    else $error("write granted below a higher qos request");
  c_aw_pass: cover property (hs && gq != 4'h0);
  c_dn_stall: cover property (dn_ar_valid_o && !dn_ar_ready_i);
  c_read_ans: cover property (rd_i ##1 rdata_o != 32'h0);
endmodule // qar_sva
`default_nettype wire

// file: tb/qar_top_tb_top.sv
// self-checking bench for the qos arbitration top
`timescale 1ns/1ps
`default_nettype none
module qar_top_tb_top;
  logic clk_i, reset_n_i, wr_i, rd_i, stall;
  logic [4:0] qos_override_enable_i, ar_valid_i, ar_dataless_i, aw_valid_i, aw_dataless_i;
  logic [4:0] ar_ready_o, aw_ready_o, r_done_i, b_done_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [4:0][3:0] ar_qos_i, aw_qos_i, read_arb_priority_hint_i;
  logic dn_ar_valid_o, dn_ar_ready_i, dn_aw_valid_o, dn_aw_ready_i;
  logic [3:0] dn_ar_qos_o, dn_aw_qos_o;
  logic [2:0] dn_ar_src_o, dn_aw_src_o;
  logic [4:0] left;
  logic [6:0] wq[$];
  logic [6:0] rq[$];
  int n_fail, checks_done;

  qar_top qar_top_i (.clk_i, .reset_n_i, .qos_override_enable_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .ar_valid_i, .ar_qos_i, .read_arb_priority_hint_i, .ar_dataless_i,
    .ar_ready_o, .r_done_i, .aw_valid_i, .aw_qos_i, .aw_dataless_i, .aw_ready_o, .b_done_i,
    .dn_ar_valid_o, .dn_ar_qos_o, .dn_ar_src_o, .dn_ar_ready_i, .dn_aw_valid_o,
    .dn_aw_qos_o, .dn_aw_src_o, .dn_aw_ready_i);
  qar_dn_model qar_dn_model_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .stall_i(stall),
    .ar_valid_i(dn_ar_valid_o), .ar_src_i(dn_ar_src_o), .aw_valid_i(dn_aw_valid_o),
    .aw_src_i(dn_aw_src_o), .ar_ready_o(dn_ar_ready_i), .aw_ready_o(dn_aw_ready_i),
    .r_done_o(r_done_i), .b_done_o(b_done_i));

  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (dn_aw_valid_o && dn_aw_ready_i) wq.push_back({dn_aw_src_o, dn_aw_qos_o});
    if (dn_ar_valid_o && dn_ar_ready_i) rq.push_back({dn_ar_src_o, dn_ar_qos_o});
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(what, rdata_o, exp);
  endtask
  // requests stay up until granted; lim bounds the wait, left tells who never got in
  task automatic issue(input logic w, input logic [4:0] m, input logic [19:0] q,
                       input logic dl, input int lim);
    @(posedge clk_i);
    left = m;
    if (w) begin
      aw_valid_i <= m;
      aw_qos_i <= q;
      aw_dataless_i <= {5{dl}};
    end else begin
      ar_valid_i <= m;
      ar_qos_i <= q;
      ar_dataless_i <= {5{dl}};
    end
    for (int k = 0; k < lim && left != 5'h00; k++) begin
      @(posedge clk_i);
      left = left & ~(w ? aw_ready_o : ar_ready_o);
      if (w) aw_valid_i <= left;
      else ar_valid_i <= left;
    end
  endtask
  task automatic pop(input logic w, input string what, input logic [6:0] exp);
    logic [6:0] got;
    got = 7'h7F;
    for (int k = 0; k < 40 && (w ? wq.size() : rq.size()) == 0; k++) @(posedge clk_i);
    if (w && wq.size() > 0) got = wq.pop_front();
    if (!w && rq.size() > 0) got = rq.pop_front();
    chk(what, {25'h0, got}, {25'h0, exp});
  endtask

  task automatic t_regs;
    rd_chk("regulator reset", 8'h10, 32'h0);
    rd_chk("status reset", 8'h14, 32'h0);
    wr_reg(8'h20, 32'h53);
    rd_chk("override readback", 8'h20, 32'h53);
    wr_reg(8'h34, 32'hFF);
    rd_chk("status read only", 8'h34, 32'h0);
    wr_reg(8'hA0, 32'h12);
    rd_chk("unmapped", 8'hA0, 32'h0);
  endtask
  task automatic t_override;
    wr_reg(8'h00, 32'h75);
    issue(1'b1, 5'h01, 20'h0, 1'b0, 40);
    pop(1'b1, "write qos no enable", 7'h00);
    qos_override_enable_i <= 5'h11;
    issue(1'b1, 5'h01, 20'h0, 1'b0, 40);
    pop(1'b1, "write qos override", 7'h07);
    issue(1'b1, 5'h01, 20'h3, 1'b0, 40);
    pop(1'b1, "write qos nonzero", 7'h03);
    issue(1'b0, 5'h01, 20'h0, 1'b0, 40);
    pop(1'b0, "read qos override", 7'h05);
  endtask
  task automatic t_prio;
    issue(1'b1, 5'h06, 20'h00520, 1'b0, 40);
    pop(1'b1, "higher qos first", 7'h25);
    pop(1'b1, "lower qos second", 7'h12);
    issue(1'b1, 5'h08, 20'h04000, 1'b0, 40);
    pop(1'b1, "single grant", 7'h34);
    issue(1'b1, 5'h18, 20'h44000, 1'b0, 40);
    pop(1'b1, "tie least recent", 7'h44);
    pop(1'b1, "tie other", 7'h34);
  endtask
  task automatic t_stall;
    stall <= 1'b1;
    issue(1'b0, 5'h08, 20'h06000, 1'b0, 40);
    repeat (6) @(posedge clk_i);
    stall <= 1'b0;
    pop(1'b0, "read after stall", 7'h36);
  endtask
  task automatic t_ot;
    wr_reg(8'h44, 32'h10);
    wr_reg(8'h48, 32'h01);
    stall <= 1'b1;
    issue(1'b0, 5'h04, 20'h0, 1'b0, 40);
    chk("first zero qos read", {27'h0, left}, 32'h0);
    issue(1'b0, 5'h04, 20'h00500, 1'b0, 40);
    chk("nonzero read not limited", {27'h0, left}, 32'h0);
    issue(1'b0, 5'h04, 20'h0, 1'b1, 40);
    chk("dataless not limited", {27'h0, left}, 32'h0);
    issue(1'b0, 5'h04, 20'h0, 1'b0, 12);
    chk("second read held", {27'h0, left}, 32'h4);
    rd_chk("read count one", 8'h54, 32'h100);
    @(posedge clk_i);
    stall <= 1'b0;
    issue(1'b0, 5'h04, 20'h0, 1'b0, 60);
    chk("held read released", {27'h0, left}, 32'h0);
    repeat (20) @(posedge clk_i);
    rq.delete();
  endtask
  // hint lifts the lower qos read past the higher one at the slave side only
  task automatic t_hint;
    read_arb_priority_hint_i <= 20'h00090;
    issue(1'b0, 5'h0A, 20'h04020, 1'b0, 40);
    pop(1'b0, "hint promotes read", 7'h12);
    pop(1'b0, "queued read keeps qos", 7'h34);
    read_arb_priority_hint_i <= 20'h0;
  endtask
  task automatic t_latency;
    wr_reg(8'h70, 32'hF0FF);
    wr_reg(8'h64, 32'h05);
    repeat (2) begin
      issue(1'b0, 5'h08, 20'h0, 1'b0, 40);
      repeat (6) @(posedge clk_i);
    end
    rd_chk("latency over target", 8'h74, 32'h1);
    wr_reg(8'h6C, 32'hFFF);
    issue(1'b0, 5'h08, 20'h0, 1'b0, 40);
    repeat (6) @(posedge clk_i);
    rd_chk("latency under target", 8'h74, 32'h0);
    rq.delete();
  endtask
  task automatic t_regulate;
    wr_reg(8'h90, 32'hF0FF);
    wr_reg(8'h84, 32'h02);
    repeat (20) @(posedge clk_i);
    rd_chk("normal mode idle", 8'h94, 32'h0);
    wr_reg(8'h84, 32'h0A);
    repeat (20) @(posedge clk_i);
    rd_chk("quiesce to max", 8'h94, 32'hF0);
    issue(1'b1, 5'h10, 20'h0, 1'b0, 40);
    pop(1'b1, "regulated write qos", 7'h4F);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    reset_n_i = 1'b0;
    {wr_i, rd_i, stall} = 3'h0;
    {qos_override_enable_i, ar_valid_i, ar_dataless_i, aw_valid_i, aw_dataless_i} = 25'h0;
    {addr_i, wdata_i} = 40'h0;
    {ar_qos_i, aw_qos_i, read_arb_priority_hint_i} = 60'h0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_regs();
    t_override();
    t_prio();
    t_stall();
    t_ot();
    t_hint();
    t_latency();
    t_regulate();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    finish_test();
  end
endmodule // qar_top_tb_top
bind qar_top qar_sva qar_sva_i (.clk_i, .reset_n_i, .rd_i, .rdata_o, .ar_valid_i, .ar_ready_o,
  .aw_valid_i, .aw_qos_i, .aw_ready_o, .dn_ar_valid_o, .dn_ar_qos_o, .dn_ar_src_o,
  .dn_ar_ready_i, .dn_aw_valid_o, .dn_aw_qos_o, .dn_aw_src_o, .dn_aw_ready_i);
`default_nettype wire
